// *** hdl/msc_sensor.sv ***
// Sensor end: serial slave with the resolution, reset, shutdown, lift and burst registers.
// Function
// - Select bit zero: resolution from legacy register.
// - Select bit one: resolution from code field.
// - Codes 1..5 map 400 to 2000 cpi.
// - Resolution register layout, reset value 0x04.
// - Writing 0x5A to 0x3A restores all defaults.
// - Soft reset code also leaves shutdown.
// - Writing 0xE7 enters shutdown until reset.
// - Shutter above threshold times 16 suppresses motion.
// - 0x3E/0x3F return inverted revision/product codes.
// - Read of 0x42 streams eight burst bytes.
// - Three burst bytes clear accumulated motion.
// - Burst may stop after X delta byte.
module msc_sensor #(
  // Arbitrary identity values.
  parameter logic [7:0] REVISION_CODE = 8'h21,
  parameter logic [7:0] PRODUCT_CODE = 8'h5C
) (
  // Link
  msc_link_if.dev link,
  input wire logic rst_n,
  // Sensor core, synchronous to the link clock
  input wire logic [7:0] motion_status,
  input wire logic [11:0] delta_x,
  input wire logic [11:0] delta_y,
  input wire logic [7:0] squal,
  input wire logic [15:0] shutter,
  input wire logic [7:0] peak_pixel,
  // Settings to the sensor core
  output logic [11:0] cpi,
  output logic shutdown,
  output logic lifted,
  output logic motion_clear
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] res_sel;
    logic [7:0] lift_thr;
    logic [7:0] legacy_cfg;
    logic shutdown;
    logic [2:0] bit_cnt;
    logic [3:0] byte_cnt;
    logic [6:0] shift_in;
    logic [6:0] addr;
    logic wr;
    logic [7:0] shift_out;
    logic [7:0] xy_high;
    logic [11:0] cpi;
    logic lifted;
    logic motion_clear;
  } msc_dev_state_s;

  localparam msc_dev_state_s ST_RESET = '{
    res_sel: msc_pkg::RES_SEL_RESET,
    lift_thr: msc_pkg::LIFT_THR_RESET,
    legacy_cfg: msc_pkg::LEGACY_CFG_RESET,
    default: '0
  };

  msc_dev_state_s st;
  msc_dev_state_s next_st;
  logic [7:0] rx_byte;
  logic [2:0] sel_code;
  logic [15:0] lift_limit;

  // ==========================================================
  // Resolution decode
  function automatic logic [11:0] cpi_of(input logic [2:0] code);
    logic [11:0] v;
    v = 12'h000;
    case (code)
      msc_pkg::RES_400: v = msc_pkg::CPI_400;
      msc_pkg::RES_800: v = msc_pkg::CPI_800;
      msc_pkg::RES_1200: v = msc_pkg::CPI_1200;
      msc_pkg::RES_1600: v = msc_pkg::CPI_1600;
      msc_pkg::RES_2000: v = msc_pkg::CPI_2000;
      default: v = 12'h000;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Read data for an address and a byte position
  function automatic logic [7:0] rd_value(input logic [6:0] a, input logic [3:0] j);
    logic [7:0] v;
    v = 8'h00;
    if (!st.shutdown) begin
      if (a == msc_pkg::ADDR_BURST) begin
        case (j)
          4'h0: begin
            v = motion_status;
            if (st.lifted) begin
              v[msc_pkg::MOTION_BIT] = 1'b0;
            end
          end
          4'h1: v = st.lifted ? 8'h00 : delta_x[7:0];
          4'h2: v = st.lifted ? 8'h00 : delta_y[7:0];
          4'h3: v = st.xy_high;
          4'h4: v = squal;
          4'h5: v = shutter[15:8];
          4'h6: v = shutter[7:0];
          4'h7: v = peak_pixel;
          default: v = 8'h00;
        endcase
      end else if (j == 4'h0) begin
        case (a)
          msc_pkg::ADDR_LEGACY_CFG: v = st.legacy_cfg;
          msc_pkg::ADDR_RES_SEL: v = st.res_sel;
          msc_pkg::ADDR_LIFT_THR: v = st.lift_thr;
          msc_pkg::ADDR_INV_REV: v = ~REVISION_CODE;
          msc_pkg::ADDR_INV_PROD: v = ~PRODUCT_CODE;
          default: v = 8'h00;
        endcase
      end
    end
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    rx_byte = {st.shift_in, link.mosi};
    next_st.motion_clear = 1'b0;
    lift_limit = {4'h0, st.lift_thr[7:1], msc_pkg::LIFT_SCALE_PAD};
    next_st.lifted = shutter > lift_limit;
    if (st.res_sel[msc_pkg::HIGH_RES_BIT]) begin
      sel_code = st.res_sel[msc_pkg::RES_CODE_LSB +: 3];
    end else begin
      sel_code = st.legacy_cfg[msc_pkg::LEGACY_RES_LSB +: 3];
    end
    next_st.cpi = cpi_of(sel_code);
    if (link.ncs) begin
      next_st.bit_cnt = 3'h0;
      next_st.byte_cnt = 4'h0;
      next_st.shift_out = 8'h00;
    end else begin
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      next_st.shift_in = rx_byte[6:0];
      next_st.shift_out = {st.shift_out[6:0], 1'b0};
      if (st.bit_cnt == 3'h7) begin
        if (st.byte_cnt != 4'hF) begin
          next_st.byte_cnt = st.byte_cnt + 4'h1;
        end
        if (st.byte_cnt == 4'h0) begin
          next_st.addr = rx_byte[6:0];
          next_st.wr = rx_byte[msc_pkg::WIRE_WRITE_BIT];
          // High nibbles are frozen so they match the low bytes read before the clear.
          next_st.xy_high = st.lifted ? 8'h00 : {delta_x[11:8], delta_y[11:8]};
          if (!rx_byte[msc_pkg::WIRE_WRITE_BIT]) begin
            next_st.shift_out = rd_value(rx_byte[6:0], 4'h0);
          end
        end else if (!st.wr) begin
          // next burst byte back to back
          next_st.shift_out = rd_value(st.addr, st.byte_cnt);
          if (st.addr == msc_pkg::ADDR_BURST && st.byte_cnt == msc_pkg::BURST_CLEAR_AT && !st.shutdown) begin
            next_st.motion_clear = 1'b1;
          end
        end else if (st.byte_cnt == 4'h1) begin
          if (!st.shutdown) begin
            case (st.addr)
              msc_pkg::ADDR_LEGACY_CFG: next_st.legacy_cfg = rx_byte;
              msc_pkg::ADDR_RES_SEL: next_st.res_sel = rx_byte & msc_pkg::RES_SEL_MASK;
              msc_pkg::ADDR_LIFT_THR: next_st.lift_thr = rx_byte & msc_pkg::LIFT_THR_MASK;
              msc_pkg::ADDR_SHUTDOWN: begin
                if (rx_byte == msc_pkg::SHUTDOWN_CODE) begin
                  next_st.shutdown = 1'b1;
                end
              end
              default: next_st.shutdown = st.shutdown;
            endcase
          end
          if (st.addr == msc_pkg::ADDR_SOFT_RST && rx_byte == msc_pkg::SOFT_RST_CODE) begin
            next_st.res_sel = msc_pkg::RES_SEL_RESET;
            next_st.lift_thr = msc_pkg::LIFT_THR_RESET;
            next_st.legacy_cfg = msc_pkg::LEGACY_CFG_RESET;
            next_st.shutdown = 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // Registers on the link clock
  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // early stop needs no cleanup
  assign link.miso = st.shift_out[7];
  assign cpi = st.cpi;
  assign shutdown = st.shutdown;
  assign lifted = st.lifted;
  assign motion_clear = st.motion_clear;
endmodule

// *** hdl/msc_pkg.sv ***
// Shared constants for the motion sensor register bank and its controller.
package msc_pkg;
  // ==========================================================
  // Sensor register offsets
  localparam logic [6:0] ADDR_LEGACY_CFG = 7'h12;
  localparam logic [6:0] ADDR_RES_SEL = 7'h36;
  localparam logic [6:0] ADDR_SOFT_RST = 7'h3A;
  localparam logic [6:0] ADDR_SHUTDOWN = 7'h3B;
  localparam logic [6:0] ADDR_LIFT_THR = 7'h3D;
  localparam logic [6:0] ADDR_INV_REV = 7'h3E;
  localparam logic [6:0] ADDR_INV_PROD = 7'h3F;
  localparam logic [6:0] ADDR_BURST = 7'h42;
  // ==========================================================
  // Reset values, codes and fields
  localparam logic [7:0] RES_SEL_RESET = 8'h04;
  localparam logic [7:0] LIFT_THR_RESET = 8'h56;
  localparam logic [7:0] LEGACY_CFG_RESET = 8'h02;
  localparam logic [7:0] SOFT_RST_CODE = 8'h5A;
  localparam logic [7:0] SHUTDOWN_CODE = 8'hE7;
  localparam logic [7:0] RES_SEL_MASK = 8'h1E;
  localparam logic [7:0] LIFT_THR_MASK = 8'hFE;
  localparam int HIGH_RES_BIT = 4;
  localparam int RES_CODE_LSB = 1;
  localparam int LEGACY_RES_LSB = 0;
  localparam int MOTION_BIT = 7;
  localparam logic [4:0] LIFT_SCALE_PAD = 5'h00;
  localparam logic [3:0] BURST_CLEAR_AT = 4'h3;
  localparam int WIRE_WRITE_BIT = 7;
  // ==========================================================
  // Resolution codes and counts per inch
  localparam logic [2:0] RES_400 = 3'h1;
  localparam logic [2:0] RES_800 = 3'h2;
  localparam logic [2:0] RES_1200 = 3'h3;
  localparam logic [2:0] RES_1600 = 3'h4;
  localparam logic [2:0] RES_2000 = 3'h5;
  localparam logic [11:0] CPI_400 = 12'h190;
  localparam logic [11:0] CPI_800 = 12'h320;
  localparam logic [11:0] CPI_1200 = 12'h4B0;
  localparam logic [11:0] CPI_1600 = 12'h640;
  localparam logic [11:0] CPI_2000 = 12'h7D0;
  // ==========================================================
  // Controller register offsets and fields
  localparam logic [3:0] HOST_CTRL = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h4;
  localparam logic [3:0] HOST_RX_LO = 4'h8;
  localparam logic [3:0] HOST_RX_HI = 4'hC;
  localparam int CTRL_WDATA_LSB = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_WRITE_BIT = 15;
  localparam int CTRL_COUNT_LSB = 16;
  localparam logic [6:0] FRAME_HDR_BITS = 7'h08;
endpackage

// *** hdl/msc_link_if.sv ***
// Four-wire serial link between the controller and the sensor.
interface msc_link_if;
  logic sclk;
  logic ncs;
  logic mosi;
  logic miso;
  modport dev (
    input sclk,
    input ncs,
    input mosi,
    output miso
  );
  modport host (
    output sclk,
    output ncs,
    output mosi,
    input miso
  );
endinterface

// *** hdl/msc_ctrl.sv ***
// Controller end: Avalon-MM command registers driving the serial link.
module msc_ctrl #(
  parameter int unsigned SCLK_HALF = 4
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Link
  msc_link_if.host link
);
  if (SCLK_HALF < 2 || SCLK_HALF > 256) begin : g_bad_half
    $error("SCLK_HALF must lie in 2..256");
  end

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SHIFT = 2'b01,
    HS_GAP = 2'b10
  } msc_hstate_e;

  typedef struct packed {
    msc_hstate_e state;
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] div_cnt;
    logic sclk;
    logic ncs;
    logic mosi;
    logic [15:0] tx;
    logic [6:0] bit_cnt;
    logic [6:0] total;
    logic [63:0] rx;
    logic busy;
    logic miso_meta;
    logic miso_sync;
  } msc_host_state_s;

  localparam msc_host_state_s ST_RESET = '{
    state: HS_IDLE,
    waitreq: 1'b1,
    sclk: 1'b1,
    ncs: 1'b1,
    default: '0
  };
  localparam logic [7:0] DIV_LAST = 8'(SCLK_HALF - 1);

  msc_host_state_s st;
  msc_host_state_s next_st;
  logic tick;
  logic rise;
  logic fall;
  logic [3:0] nbytes;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.miso_meta = link.miso;
    next_st.miso_sync = st.miso_meta;
    tick = st.div_cnt == DIV_LAST;
    rise = tick && !st.sclk;
    fall = tick && st.sclk;
    next_st.div_cnt = tick ? 8'h00 : st.div_cnt + 8'h01;
    if (tick) begin
      next_st.sclk = !st.sclk;
    end
    nbytes = {1'b0, writedata[msc_pkg::CTRL_COUNT_LSB +: 3]} + 4'h1;
    // Bus answer one cycle after the request is seen.
    next_st.waitreq = !((read || write) && st.waitreq);
    if ((read || write) && st.waitreq) begin
      case (address)
        msc_pkg::HOST_STATUS: next_st.rdata = {31'h0, st.busy};
        msc_pkg::HOST_RX_LO: next_st.rdata = st.rx[31:0];
        msc_pkg::HOST_RX_HI: next_st.rdata = st.rx[63:32];
        default: next_st.rdata = 32'h0;
      endcase
    end
    if (write && !st.waitreq && address == msc_pkg::HOST_CTRL && !st.busy) begin
      // code writes are single write frames
      next_st.busy = 1'b1;
      next_st.rx = 64'h0;
      next_st.tx = {writedata[msc_pkg::CTRL_WRITE_BIT], writedata[msc_pkg::CTRL_ADDR_LSB +: 7],
                    writedata[msc_pkg::CTRL_WDATA_LSB +: 8]};
      if (writedata[msc_pkg::CTRL_WRITE_BIT]) begin
        next_st.total = msc_pkg::FRAME_HDR_BITS + msc_pkg::FRAME_HDR_BITS;
      end else begin
        // read count may end a burst early
        next_st.total = {nbytes, 3'h0} + msc_pkg::FRAME_HDR_BITS;
      end
    end
    case (st.state)
      HS_IDLE: begin
        if (st.busy && fall) begin
          next_st.ncs = 1'b0;
          next_st.mosi = st.tx[15];
          next_st.tx = {st.tx[14:0], 1'b0};
          next_st.bit_cnt = 7'h00;
          next_st.state = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        if (rise) begin
          next_st.bit_cnt = st.bit_cnt + 7'h01;
          if (st.bit_cnt >= msc_pkg::FRAME_HDR_BITS) begin
            next_st.rx = {st.rx[62:0], st.miso_sync};
          end
        end
        if (fall) begin
          if (st.bit_cnt == st.total) begin
            next_st.ncs = 1'b1;
            next_st.mosi = 1'b0;
            next_st.state = HS_GAP;
          end else begin
            next_st.mosi = st.tx[15];
            next_st.tx = {st.tx[14:0], 1'b0};
          end
        end
      end
      HS_GAP: begin
        if (fall) begin
          next_st.busy = 1'b0;
          next_st.state = HS_IDLE;
        end
      end
      default: next_st.state = HS_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign readdata = st.rdata;
  assign waitrequest = st.waitreq;
  assign link.sclk = st.sclk;
  assign link.ncs = st.ncs;
  assign link.mosi = st.mosi;
endmodule

// *** testbench/msc_link_monitor.sv ***
// Assertions on the serial link between the controller and the sensor.
module msc_link_monitor (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Link
  input wire logic sclk,
  input wire logic ncs,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_q;
  logic [7:0] rises;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Rising link clock edges counted within one frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b1;
      rises <= 8'h00;
    end else begin
      sclk_q <= sclk;
      rises <= ncs ? 8'h00 : rises + {7'h00, sclk & !sclk_q};
    end
  end

  // ==========================================================
  // Link timing
  a_sclk_low_half: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("link clock low phase wrong");
  a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*4])
    else $error("link clock high phase short");
  a_mosi_at_fall: assert property ($changed(mosi) |-> $fell(sclk))
    else $error("data to sensor changed off the falling edge");
  a_ncs_at_fall: assert property ($changed(ncs) |-> $fell(sclk))
    else $error("select changed off the falling edge");
  a_miso_at_rise: assert property ($changed(miso) |-> $rose(sclk))
    else $error("data to controller changed off the rising edge");
  a_select_gap: assert property ($rose(ncs) |-> ncs [*8])
    else $error("select high too briefly between frames");
  a_frame_whole_bytes: assert property ($rose(ncs) |-> rises[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  a_frame_length: assert property ($rose(ncs) |-> rises >= 8'h10 && rises <= 8'h48)
    else $error("frame length out of range");
endmodule

// *** testbench/motion_sensor_config_regs_tb.sv ***
// Self-checking bench joining the controller and the sensor over the serial link.
module motion_sensor_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Arbitrary identity values.
  localparam logic [7:0] REV = 8'h3A;
  localparam logic [7:0] PROD = 8'h91;
  localparam int CEILING = 40000;
  localparam logic [6:0] RA [4] = '{7'h36, 7'h3D, 7'h3E, 7'h3F};
  localparam logic [7:0] RE [4] = '{8'h04, 8'h56, ~REV, ~PROD};
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [7:0] motion_status = 8'h00;
  logic [11:0] delta_x = 12'h000;
  logic [11:0] delta_y = 12'h000;
  logic [7:0] squal = 8'h00;
  logic [15:0] shutter = 16'h0000;
  logic [7:0] peak_pixel = 8'h00;
  logic [11:0] cpi;
  logic shutdown;
  logic lifted;
  logic motion_clear;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int clears = 0;

  msc_link_if link ();
  msc_ctrl msc_ctrl_inst (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .link(link));
  msc_sensor #(.REVISION_CODE(REV), .PRODUCT_CODE(PROD)) msc_sensor_inst (.link(link), .rst_n(rst_n),
    .motion_status(motion_status), .delta_x(delta_x), .delta_y(delta_y), .squal(squal), .shutter(shutter),
    .peak_pixel(peak_pixel), .cpi(cpi), .shutdown(shutdown), .lifted(lifted), .motion_clear(motion_clear));
  msc_link_monitor msc_link_monitor_inst (.clk(clk), .rst_n(rst_n), .sclk(link.sclk), .ncs(link.ncs),
    .mosi(link.mosi), .miso(link.miso));

  always #25 clk = ~clk;
  always @(posedge link.sclk) begin
    if (motion_clear === 1'b1) clears <= clears + 1;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Tasks and expectations
  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic frame(input logic wr, input logic [6:0] a, input logic [7:0] d, input int n, output logic [63:0] rx);
    logic [31:0] q;
    logic [31:0] lo;
    bus(msc_pkg::HOST_CTRL, 1'b1, {13'h0, 3'(n - 1), wr, a, d}, q);
    do bus(msc_pkg::HOST_STATUS, 1'b0, 32'h0, q); while (q[0] !== 1'b0);
    bus(msc_pkg::HOST_RX_LO, 1'b0, 32'h0, lo);
    bus(msc_pkg::HOST_RX_HI, 1'b0, 32'h0, q);
    rx = {q, lo};
    repeat (16) @(posedge clk);
  endtask

  task automatic defaults();
    logic [63:0] rx;
    for (int i = 0; i < 4; i++) begin
      frame(1'b0, RA[i], 8'h00, 1, rx);
      chk(64'(rx[7:0]), 64'(RE[i]), "default value");
    end
  endtask

  function automatic logic [11:0] cpi_of(input logic [2:0] c);
    case (c)
      3'h1: return msc_pkg::CPI_400;
      3'h2: return msc_pkg::CPI_800;
      3'h3: return msc_pkg::CPI_1200;
      3'h4: return msc_pkg::CPI_1600;
      3'h5: return msc_pkg::CPI_2000;
      default: return 12'h000;
    endcase
  endfunction

  function automatic logic [63:0] burst_of(input logic lift);
    return {motion_status & (lift ? 8'h7F : 8'hFF),
      lift ? 24'h000000 : {delta_x[7:0], delta_y[7:0], delta_x[11:8], delta_y[11:8]}, squal, shutter, peak_pixel};
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    logic [63:0] rx;
    logic [31:0] q;
    logic [7:0] thr;
    int c0;
    logic [63:0] ex;
    void'($urandom(32'h85eef730));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (16) @(posedge clk);
    chk(64'(cpi), 64'(msc_pkg::CPI_800), "cpi after reset");
    defaults();
    bus(4'h2, 1'b0, 32'h0, q);
    chk(64'(q), 64'h0, "unmapped read");
    for (int c = 0; c < 8; c++) begin
      frame(1'b1, msc_pkg::ADDR_RES_SEL, {4'h1, 3'(c), 1'b0}, 1, rx);
      chk(64'(cpi), 64'(cpi_of(3'(c))), "cpi by code");
      frame(1'b0, msc_pkg::ADDR_RES_SEL, 8'h00, 1, rx);
      chk(64'(rx[7:0]), 64'({4'h1, 3'(c), 1'b0}), "resolution readback");
    end
    frame(1'b1, msc_pkg::ADDR_RES_SEL, 8'h0A, 1, rx);
    chk(64'(cpi), 64'(msc_pkg::CPI_800), "legacy cpi");
    frame(1'b1, msc_pkg::ADDR_LEGACY_CFG, 8'h03, 1, rx);
    chk(64'(cpi), 64'(msc_pkg::CPI_1200), "legacy cpi");
    frame(1'b0, msc_pkg::ADDR_LEGACY_CFG, 8'h00, 1, rx);
    chk(64'(rx[7:0]), 64'h03, "legacy readback");
    frame(1'b1, msc_pkg::ADDR_RES_SEL, 8'h1A, 1, rx);
    chk(64'(cpi), 64'(msc_pkg::CPI_2000), "legacy ignored");
    for (int i = 0; i < 6; i++) begin
      thr = 8'($urandom());
      motion_status <= 8'($urandom());
      delta_x <= 12'($urandom());
      delta_y <= 12'($urandom());
      squal <= 8'($urandom());
      peak_pixel <= 8'($urandom());
      shutter <= (i < 2) ? {4'h0, thr[7:1], 5'h00} + 16'(i) : 16'($urandom_range(4200));
      frame(1'b1, msc_pkg::ADDR_LIFT_THR, thr, 1, rx);
      chk(64'(lifted), 64'(shutter > {4'h0, thr[7:1], 5'h00}), "lifted");
      c0 = clears;
      frame(1'b0, msc_pkg::ADDR_BURST, 8'h00, 8, rx);
      chk(rx, burst_of(shutter > {4'h0, thr[7:1], 5'h00}), "burst bytes");
      chk(64'(clears), 64'(c0 + 1), "motion clear");
    end
    ex = burst_of(shutter > {4'h0, thr[7:1], 5'h00});
    c0 = clears;
    frame(1'b0, msc_pkg::ADDR_BURST, 8'h00, 2, rx);
    chk(64'(rx[15:0]), 64'(ex[63:48]), "short burst");
    chk(64'(clears), 64'(c0), "no early clear");
    frame(1'b0, msc_pkg::ADDR_BURST, 8'h00, 3, rx);
    chk(64'(rx[23:0]), 64'(ex[63:40]), "three byte burst");
    chk(64'(clears), 64'(c0 + 1), "clear after three");
    frame(1'b1, msc_pkg::ADDR_SHUTDOWN, 8'hE6, 1, rx);
    chk(64'(shutdown), 64'h0, "wrong shutdown code");
    frame(1'b1, msc_pkg::ADDR_SHUTDOWN, msc_pkg::SHUTDOWN_CODE, 1, rx);
    chk(64'(shutdown), 64'h1, "shutdown");
    frame(1'b1, msc_pkg::ADDR_RES_SEL, 8'h16, 1, rx);
    frame(1'b0, msc_pkg::ADDR_RES_SEL, 8'h00, 1, rx);
    chk(64'(rx[7:0]), 64'h0, "read in shutdown");
    frame(1'b1, msc_pkg::ADDR_SOFT_RST, 8'h5B, 1, rx);
    chk(64'(shutdown), 64'h1, "wrong reset code");
    frame(1'b1, msc_pkg::ADDR_SOFT_RST, msc_pkg::SOFT_RST_CODE, 1, rx);
    chk(64'(shutdown), 64'h0, "wake by reset");
    chk(64'(cpi), 64'(msc_pkg::CPI_800), "cpi default");
    defaults();
    tally_and_finish();
  end
endmodule
